// ===== pin_sync.sv
// Purpose: two-stage synchroniser for the port pin inputs
// Assumes: pins are asynchronous to i_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module pin_sync (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // pins
  input wire logic [port_a_pkg::PIN_COUNT-1:0] i_pin,
  output logic [port_a_pkg::PIN_COUNT-1:0] o_pin_sync
);
  import port_a_pkg::*;

  logic [PIN_COUNT-1:0] stage1_reg;

  // ==========================================================
  // synchroniser
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      stage1_reg <= PIN_DATA_RESET;
      o_pin_sync <= PIN_DATA_RESET;
    end else begin
      stage1_reg <= i_pin;
      o_pin_sync <= stage1_reg;
    end
  end
endmodule

// ===== port_a_far.sv
// Purpose: serial master and board pins
// Assumes: board always drives free pins
// Notes: master drives clock, master-out; it claims pins 5,4 too, which the block must refuse
`timescale 1ns/10ps
module port_a_far (
  // control
  input wire logic i_own,
  input wire logic [5:0] i_board,
  input wire port_a_pkg::pin_drive_type i_drive,
  // far side
  output port_a_pkg::serial_ctrl_type o_serial,
  output logic [5:0] o_level
);
  import port_a_pkg::*;
  assign o_serial = '{own: {6{i_own}}, drive_enable: 6'h06, drive_value: 6'h04};
  assign o_level = i_drive.oe & i_drive.out | ~i_drive.oe & i_board;
endmodule

// ===== port_a_gpio_spi_share.sv
// Purpose: port A general purpose pins shared with the serial interface
// Assumes: one clock, synchronous active-low reset, byte register port
// Notes: pin outputs are registered, so pins follow registers one cycle later
//
// Behaviour
// - data read gives stored bit for outputs, synchronised pin level for inputs.
// - pins 3,2,1,0 carry select, clock, master-out, master-in; pins 5,4 none.
// - pins not used by the serial interface act as general purpose pins.
// - serial interface sets owned pin direction; stored direction bit stays unchanged.
// - general purpose direction 1 drives data register, 0 leaves pin undriven.
// - direction holds bits 5..0; bits 7,6 of data and direction read zero.
// - both reserved bytes read zero and ignore writes.
// - data and direction registers readable and writable at any time.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
module port_a_gpio_spi_share (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // register port
  input wire port_a_pkg::reg_req_type i_req,
  output logic [port_a_pkg::DATA_WIDTH-1:0] o_rdata,
  // serial interface side
  input wire port_a_pkg::serial_ctrl_type i_serial,
  output logic [port_a_pkg::PIN_COUNT-1:0] o_serial_pin_in,
  // package pins
  input wire logic [port_a_pkg::PIN_COUNT-1:0] i_pin,
  output port_a_pkg::pin_drive_type o_pin
);
  import port_a_pkg::*;

  logic [PIN_COUNT-1:0] pin_data_reg;
  logic [PIN_COUNT-1:0] pin_direction_reg;
  logic [PIN_COUNT-1:0] pin_level;
  logic [PIN_COUNT-1:0] own_mask;
  logic [PIN_COUNT-1:0] data_view;
  logic [DATA_WIDTH-1:0] rdata_next;
  pin_drive_type pin_next;

  // ==========================================================
  // input synchroniser
  pin_sync u_pin_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pin(i_pin),
    .o_pin_sync(pin_level)
  );

  // pins 5 and 4 cannot be claimed even if the interface asserts ownership
  assign own_mask = i_serial.own & SERIAL_CAPABLE_MASK;

  // ==========================================================
  // register writes
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pin_data_reg <= PIN_DATA_RESET;
    end else if (i_req.write && i_req.addr == OFFSET_PIN_DATA) begin
      pin_data_reg <= i_req.wdata[PIN_COUNT-1:0];
    end
  end

  // the direction bit is written by software only, never by ownership changes
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pin_direction_reg <= PIN_DIRECTION_RESET;
    end else if (i_req.write && i_req.addr == OFFSET_PIN_DIRECTION) begin
      pin_direction_reg <= i_req.wdata[PIN_COUNT-1:0];
    end
  end

  // ==========================================================
  // read path
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : gen_view
      assign data_view[g] = pin_direction_reg[g] ? pin_data_reg[g] : pin_level[g];
    end
  endgenerate

  always_comb begin
    rdata_next = READ_ZERO;
    if (i_req.read) begin
      case (i_req.addr)
        OFFSET_PIN_DATA: rdata_next = {UPPER_ZERO, data_view};
        OFFSET_PIN_DIRECTION: rdata_next = {UPPER_ZERO, pin_direction_reg};
        OFFSET_RESERVED_AFTER_DATA: rdata_next = READ_ZERO;
        OFFSET_RESERVED_AFTER_DIRECTION: rdata_next = READ_ZERO;
        default: rdata_next = READ_ZERO;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rdata <= READ_ZERO;
    end else begin
      o_rdata <= rdata_next;
    end
  end

  // ==========================================================
  // pin drive multiplexing
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : gen_drive
      // owned pins take the interface's drive, free pins the registers
      assign pin_next.oe[g] = own_mask[g] ? i_serial.drive_enable[g] : pin_direction_reg[g];
      assign pin_next.out[g] = own_mask[g] ? i_serial.drive_value[g] : pin_data_reg[g];
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_pin <= '0;
    end else begin
      o_pin <= pin_next;
    end
  end

  // synchronised levels go to the serial interface for its input pins
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_serial_pin_in <= PIN_DATA_RESET;
    end else begin
      o_serial_pin_in <= pin_level & own_mask;
    end
  end
endmodule

// ===== port_a_gpio_spi_share_test.sv
// Purpose: port A tests
// Assumes: far model resolves pins
// Notes: pins settle 3 edges
`timescale 1ns/10ps
module port_a_gpio_spi_share_test;
  import port_a_pkg::*;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic own = 1'b0;
  logic [5:0] board = 6'h2a;
  reg_req_type req = '0;
  serial_ctrl_type ser;
  pin_drive_type drv;
  logic [7:0] rdata;
  logic [5:0] level;
  logic [5:0] spin;
  int failures = 0;
  int n_tests = 0;
  port_a_gpio_spi_share i_port_a_gpio_spi_share (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(req),
    .o_rdata(rdata), .i_serial(ser), .o_serial_pin_in(spin), .i_pin(level), .o_pin(drv));
  port_a_far i_port_a_far (.i_own(own), .i_board(board), .i_drive(drv), .o_serial(ser), .o_level(level));
  initial forever #12.5 i_clk = ~i_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [1:0] a, input logic [7:0] d, input logic w);
    @(posedge i_clk);
    req <= '{addr: a, wdata: d, write: w, read: !w};
    @(posedge i_clk);
    req <= '0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    acc(a, 8'h00, 1'b0);
    #1 chk(rdata, exp);
  endtask
  task automatic wait_oe(input logic [7:0] exp);
    repeat (3) @(posedge i_clk);
    chk({2'h0, drv.oe}, exp);
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge i_clk);
    failures++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clk);
    acc(2'h1, 8'hff, 1'b1);
    acc(2'h3, 8'hff, 1'b1);
    for (int a = 1; a < 4; a++) rd(a[1:0], 8'h00);
    rd(2'h0, 8'h2a);
    acc(2'h2, 8'hff, 1'b1);
    rd(2'h2, 8'h3f);
    rd(2'h0, 8'h00);
    acc(2'h0, 8'hd5, 1'b1);
    rd(2'h0, 8'h15);
    chk({2'h0, drv.out}, 8'h15);
    acc(2'h2, 8'h0f, 1'b1);
    wait_oe(8'h0f);
    rd(2'h0, 8'h25);
    @(posedge i_clk);
    own <= 1'b1;
    wait_oe(8'h06);
    chk({2'h0, drv.out}, 8'h14);
    rd(2'h2, 8'h0f);
    chk({2'h0, spin}, 8'h0c);
    acc(2'h2, 8'h30, 1'b1);
    wait_oe(8'h36);
    own <= 1'b0;
    wait_oe(8'h30);
    chk({2'h0, spin}, 8'h00);
    print_verdict();
  end
endmodule

// ===== port_a_pkg.sv
// Purpose: shared constants and types for the port A pin block
// Assumes: byte-wide register port, 8-bit data, 6 port pins
// Notes: offsets are byte addresses of the register port
package port_a_pkg;
  localparam int unsigned PIN_COUNT = 6;
  localparam int unsigned ADDR_WIDTH = 2;
  localparam int unsigned DATA_WIDTH = 8;

  // ==========================================================
  // register map
  localparam logic [1:0] OFFSET_PIN_DATA = 2'h0;
  localparam logic [1:0] OFFSET_RESERVED_AFTER_DATA = 2'h1;
  localparam logic [1:0] OFFSET_PIN_DIRECTION = 2'h2;
  localparam logic [1:0] OFFSET_RESERVED_AFTER_DIRECTION = 2'h3;

  localparam logic [5:0] PIN_DATA_RESET = 6'h00;
  localparam logic [5:0] PIN_DIRECTION_RESET = 6'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [1:0] UPPER_ZERO = 2'h0;

  // ==========================================================
  // serial interface pin positions
  localparam int unsigned PIN_SLAVE_SELECT = 3;
  localparam int unsigned PIN_SERIAL_CLOCK = 2;
  localparam int unsigned PIN_MASTER_OUT = 1;
  localparam int unsigned PIN_MASTER_IN = 0;
  localparam logic [5:0] SERIAL_CAPABLE_MASK = 6'h0f;

  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
    logic write;
    logic read;
  } reg_req_type;

  // per-pin control from the serial interface
  typedef struct packed {
    logic [PIN_COUNT-1:0] own;
    logic [PIN_COUNT-1:0] drive_enable;
    logic [PIN_COUNT-1:0] drive_value;
  } serial_ctrl_type;

  typedef struct packed {
    logic [PIN_COUNT-1:0] out;
    logic [PIN_COUNT-1:0] oe;
  } pin_drive_type;
endpackage

// ===== port_a_props.sv
// Purpose: port A checks
// Assumes: bound to the top
// Notes: reads lag pins 3 edges
`timescale 1ns/10ps
module port_a_props (
  // watched ports
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire port_a_pkg::reg_req_type i_req,
  input wire logic [7:0] o_rdata,
  input wire port_a_pkg::serial_ctrl_type i_serial,
  input wire logic [5:0] o_serial_pin_in,
  input wire logic [5:0] i_pin,
  input wire port_a_pkg::pin_drive_type o_pin
);
  import port_a_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_owned;
    (i_resetn && i_serial.own[3:0] == 4'hf) [*4];
  endsequence
  a_rd_idle: assert property (!$past(i_req.read) |-> o_rdata == 8'h00) else $error("rdata");
  a_upper_zero: assert property (o_rdata[7:6] == 2'h0) else $error("upper");
  a_rsvd_zero: assert property ($past(i_req.read && i_req.addr[0]) |-> !o_rdata) else $error("rsvd");
  a_data_view: assert property ($past(i_req.read && i_req.addr == 2'h0 && !i_serial.own) |->
    o_rdata[5:0] == (o_pin.oe & o_pin.out | ~o_pin.oe & $past(i_pin, 3))) else $error("data");
  a_dir_read: assert property ($past(i_req.read && i_req.addr == 2'h2 && !i_serial.own) |->
    o_rdata[5:0] == o_pin.oe) else $error("dir");
  a_own_drive: assert property (i_serial.own[3:0] == 4'hf |=>
    o_pin.oe[3:0] == $past(i_serial.drive_enable[3:0])) else $error("own");
  a_high_pins: assert property (o_serial_pin_in[5:4] == 2'h0) else $error("high");
  a_serial_in: assert property (s_owned |-> o_serial_pin_in[3:0] == $past(i_pin[3:0], 3)) else $error("sin");
endmodule
bind port_a_gpio_spi_share port_a_props i_port_a_props (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(i_req),
  .o_rdata(o_rdata), .i_serial(i_serial), .o_serial_pin_in(o_serial_pin_in), .i_pin(i_pin), .o_pin(o_pin));
